// >>> rtl/pcs_seq.sv
`timescale 1ns/1ps
module pcs_seq #(
  parameter int DEPTH = pcs_pkg::STACK_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        fetch,
  input  wire logic        jump,
  input  wire logic        call,
  input  wire logic [10:0] target,
  input  wire logic        irq_vector,
  input  wire logic        ret,
  input  wire logic        low_wr,
  input  wire logic [7:0]  low_wdata,
  input  wire logic        latch_wr,
  input  wire logic [7:0]  latch_wdata,
  output logic      [12:0] pc,
  output logic      [7:0]  pc_low_byte_reg,
  output logic      [7:0]  pc_high_holding_latch
);
  // ********************
  // stack connection
  // ********************
  pcs_stack_if stk ();
  logic [12:0] next_pc;
  logic [12:0] pc_inc;

  // call return address is the counter already advanced past the branch; a vector pushes the counter itself
  assign pc_inc        = pc + 13'h0001;
  assign stk.push      = call || irq_vector;
  assign stk.pop       = ret && !call && !jump && !irq_vector;
  assign stk.push_data = irq_vector ? pc : pc_inc;

  pcs_stack #(.DEPTH(DEPTH)) u_stack (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .stk     (stk)
  );

  // ********************
  // next counter value
  // ********************
  always_comb begin
    next_pc = pc;
    if (irq_vector) begin
      next_pc = pcs_pkg::IRQ_VECTOR;
    end else if (call || jump) begin
      next_pc = {pc_high_holding_latch[4:3], target};
    end else if (ret) begin
      next_pc = stk.top_data;
    end else if (low_wr) begin
      next_pc = {pc_high_holding_latch[4:0], low_wdata};
    end else if (fetch) begin
      next_pc = pc_inc;
    end
  end

  // ********************
  // counter and latch
  // ********************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc <= pcs_pkg::PC_RESET;
    end else if (clk_en) begin
      pc <= next_pc;
    end
  end

  assign pc_low_byte_reg = pc[7:0];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc_high_holding_latch <= pcs_pkg::LATCH_RESET;
    end else if (clk_en && latch_wr) begin
      pc_high_holding_latch <= latch_wdata;
    end
  end

  // ********************
  // checks
  // ********************
  chk_low_write_load: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && low_wr && !irq_vector && !call && !jump && !ret)
      |=> pc == {$past(pc_high_holding_latch[4:0]), $past(low_wdata)})
    else $error("low byte write did not load upper bits");
  chk_page_target: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && (call || jump) && !irq_vector)
      |=> pc == {$past(pc_high_holding_latch[4:3]), $past(target)})
    else $error("branch target wrong");
  chk_fetch_inc: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && fetch && !irq_vector && !call && !jump && !ret && !low_wr)
      |=> pc == $past(pc) + 13'h0001)
    else $error("fetch did not advance");
  chk_call_return: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && call && !irq_vector) ##1 (clk_en && ret && !call && !jump && !irq_vector)
      |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return address wrong");
  chk_latch_kept: assert property (@(posedge clk_sys) disable iff (reset)
    (!latch_wr) |=> $stable(pc_high_holding_latch))
    else $error("holding latch changed");
  chk_freeze: assert property (@(posedge clk_sys) disable iff (reset)
    (!clk_en) |=> $stable(pc))
    else $error("counter moved while frozen");
  chk_irq_vector: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && irq_vector) |=> pc == pcs_pkg::IRQ_VECTOR)
    else $error("vector not taken");
  chk_reset_clear: assert property (@(posedge clk_sys)
    $fell(reset) |-> pc[12:8] == 5'h00)
    else $error("upper bits not cleared");

  // ********************
  // check helpers
  // ********************
  localparam int SLOT_W = $clog2(DEPTH);

  logic                take_irq;
  logic                take_branch;
  logic                take_call;
  logic                take_pop;
  logic                take_low;
  logic                take_fetch;
  logic                take_idle;
  logic                take_latch;
  logic [12:0]         shadow [DEPTH];
  logic [DEPTH-1:0]    shadow_ok;
  logic [SLOT_W-1:0]   shadow_ptr;
  logic [SLOT_W-1:0]   shadow_top_idx;
  logic [12:0]         shadow_top;
  logic                shadow_top_ok;

  // events as the priority order resolves them
  assign take_irq    = clk_en && irq_vector;
  assign take_branch = clk_en && (call || jump) && !irq_vector;
  assign take_call   = clk_en && call && !irq_vector;
  assign take_pop    = clk_en && ret && !call && !jump && !irq_vector;
  assign take_low    = clk_en && low_wr && !ret && !call && !jump && !irq_vector;
  assign take_fetch  = clk_en && fetch && !low_wr && !ret && !call && !jump && !irq_vector;
  assign take_idle   = clk_en && !fetch && !low_wr && !ret && !call && !jump && !irq_vector;
  assign take_latch  = clk_en && latch_wr;

  // independent copy of the return stack
  assign shadow_top_idx = shadow_ptr - 1'b1;
  assign shadow_top     = shadow[shadow_top_idx];
  assign shadow_top_ok  = shadow_ok[shadow_top_idx];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shadow_ptr <= SLOT_W'(pcs_pkg::PTR_RESET);
    end else if (take_irq || take_call) begin
      shadow_ptr <= shadow_ptr + 1'b1;
    end else if (take_pop) begin
      shadow_ptr <= shadow_top_idx;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_shadow
    logic [12:0] entry;
    logic        valid;

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        entry <= pcs_pkg::PC_RESET;
        valid <= 1'b0;
      end else if ((take_irq || take_call) && shadow_ptr == SLOT_W'(i)) begin
        entry <= stk.push_data;
        valid <= 1'b1;
      end
    end

    assign shadow[i]    = entry;
    assign shadow_ok[i] = valid;
  end

  // ********************
  // stack checks
  // ********************
  chk_pop_value: assert property (@(posedge clk_sys) disable iff (reset)
    (take_pop && shadow_top_ok)
      |=> pc == $past(shadow_top))
    else $error("popped value wrong");

  chk_call_top: assert property (@(posedge clk_sys) disable iff (reset)
    take_call
      |=> stk.top_data == $past(pc) + 13'h0001)
    else $error("call pushed wrong address");

  chk_irq_top: assert property (@(posedge clk_sys) disable iff (reset)
    take_irq
      |=> stk.top_data == $past(pc))
    else $error("vector pushed wrong address");

  chk_irq_return: assert property (@(posedge clk_sys) disable iff (reset)
    take_irq ##1 take_pop
      |=> pc == $past(pc, 2))
    else $error("interrupt exit address wrong");

  chk_jump_no_push: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && jump && !call && !irq_vector)
      |=> $stable(stk.top_data))
    else $error("jump touched the stack");

  chk_low_no_stack: assert property (@(posedge clk_sys) disable iff (reset)
    take_low
      |=> $stable(stk.top_data))
    else $error("low byte write touched the stack");

  chk_fetch_no_stack: assert property (@(posedge clk_sys) disable iff (reset)
    take_fetch
      |=> $stable(stk.top_data))
    else $error("fetch touched the stack");

  chk_idle_no_stack: assert property (@(posedge clk_sys) disable iff (reset)
    take_idle
      |=> $stable(stk.top_data))
    else $error("idle cycle touched the stack");

  chk_stack_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    (!clk_en)
      |=> $stable(stk.top_data))
    else $error("stack moved while frozen");

  chk_ret_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && ret && call && !irq_vector)
      |=> stk.top_data == $past(pc) + 13'h0001)
    else $error("return not ignored beside a call");

  // ********************
  // counter checks
  // ********************
  chk_idle_hold: assert property (@(posedge clk_sys) disable iff (reset)
    take_idle
      |=> $stable(pc))
    else $error("counter moved without an event");

  chk_fetch_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    (take_fetch && pc == 13'h1FFF)
      |=> pc == 13'h0000)
    else $error("fetch did not wrap");

  chk_fetch_carry: assert property (@(posedge clk_sys) disable iff (reset)
    (take_fetch && pc[7:0] == 8'hFF)
      |=> pc[12:8] == $past(pc[12:8]) + 5'h01)
    else $error("fetch did not carry");

  chk_low_no_carry: assert property (@(posedge clk_sys) disable iff (reset)
    take_low
      |=> pc[12:8] == $past(pc_high_holding_latch[4:0]))
    else $error("low byte write carried");

  chk_low_byte_write: assert property (@(posedge clk_sys) disable iff (reset)
    take_low
      |=> pc_low_byte_reg == $past(low_wdata))
    else $error("low byte not written");

  chk_branch_page: assert property (@(posedge clk_sys) disable iff (reset)
    take_branch
      |=> pc[12:11] == $past(pc_high_holding_latch[4:3]))
    else $error("branch left the page");

  chk_branch_offset: assert property (@(posedge clk_sys) disable iff (reset)
    take_branch
      |=> pc[10:0] == $past(target))
    else $error("branch offset wrong");

  chk_low_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    (!clk_en)
      |=> $stable(pc_low_byte_reg))
    else $error("low byte moved while frozen");

  chk_vector_low: assert property (@(posedge clk_sys) disable iff (reset)
    take_irq
      |=> pc_low_byte_reg == pcs_pkg::IRQ_VECTOR[7:0])
    else $error("vector low byte wrong");

  // ********************
  // latch and reset checks
  // ********************
  chk_latch_load: assert property (@(posedge clk_sys) disable iff (reset)
    take_latch
      |=> pc_high_holding_latch == $past(latch_wdata))
    else $error("holding latch not loaded");

  chk_latch_frozen: assert property (@(posedge clk_sys) disable iff (reset)
    (!clk_en)
      |=> $stable(pc_high_holding_latch))
    else $error("holding latch moved while frozen");

  chk_pop_latch: assert property (@(posedge clk_sys) disable iff (reset)
    (take_pop && !latch_wr)
      |=> $stable(pc_high_holding_latch))
    else $error("pop changed the holding latch");

  chk_push_latch: assert property (@(posedge clk_sys) disable iff (reset)
    ((take_irq || take_call) && !latch_wr)
      |=> $stable(pc_high_holding_latch))
    else $error("push changed the holding latch");

  chk_reset_value: assert property (@(posedge clk_sys)
    $fell(reset)
      |-> pc == pcs_pkg::PC_RESET)
    else $error("counter not cleared");

  chk_reset_latch: assert property (@(posedge clk_sys)
    $fell(reset)
      |-> pc_high_holding_latch == pcs_pkg::LATCH_RESET)
    else $error("holding latch not cleared");

  chk_reset_stack: assert property (@(posedge clk_sys)
    $fell(reset)
      |-> stk.top_data == pcs_pkg::PC_RESET)
    else $error("stack top not cleared");
endmodule : pcs_seq

// >>> rtl/pcs_pkg.sv
// What this block does
// - the program counter is 13 bits wide and its low byte can be read and written by the core.
// - the upper counter bits 12 to 8 cannot be read and have no direct write; a low byte write loads them from the holding latch.
// - any reset clears the upper counter bits.
// - a write to the low byte loads the upper bits from holding latch bits 4 to 0 at the same time.
// - a call or jump target is the 11 instruction address bits with holding latch bits 4 and 3 on top.
// - the space is 8K words in 2K pages, and a call or jump alone stays within the selected page.
// - a sum written to the low byte does not carry into the upper bits, so computed jumps wrap per 256 words.
// - an 8 by 13 bit return stack lies outside program and data space and its pointer is hidden.
// - a call pushes the counter plus one and an interrupt vector pushes the counter itself onto the stack.
// - a return, a return with literal or an interrupt exit pops the full 13-bit counter.
// - pushes and pops leave the holding latch unchanged.
// - the stack is circular, so the ninth push overwrites the first.
// - there is no overflow or underflow status and no explicit push or pop.
// - holding latch bits 2 to 0 take no part in call or jump addressing.
package pcs_pkg;
  localparam int          PC_W        = 13;
  localparam int          LOW_W       = 8;
  localparam int          PAGE_W      = 11;
  localparam int          STACK_DEPTH = 8;
  localparam int          PTR_W       = 3;
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
  localparam logic [2:0]  PTR_RESET   = 3'h0;
endpackage : pcs_pkg

// >>> rtl/pcs_stack_if.sv
`timescale 1ns/1ps
interface pcs_stack_if;
  logic        push;
  logic        pop;
  logic [12:0] push_data;
  logic [12:0] top_data;
  modport seq (output push, output pop, output push_data, input top_data);
  modport mem (input push, input pop, input push_data, output top_data);
endinterface : pcs_stack_if

// >>> rtl/pcs_stack.sv
`timescale 1ns/1ps
module pcs_stack #(
  parameter int DEPTH = 8
) (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  input  wire logic  clk_en,
  pcs_stack_if.mem   stk
);
  // ********************
  // circular storage
  // ********************
  logic [12:0]                mem [DEPTH];
  logic [$clog2(DEPTH)-1:0]   ptr;
  logic [$clog2(DEPTH)-1:0]   ptr_m1;
  logic [$clog2(DEPTH)-1:0]   ptr_m2;

  assign ptr_m1 = ptr - 1'b1;
  assign ptr_m2 = ptr - 2'd2;

  // pointer is hidden and simply wraps; no overflow flag exists
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ptr <= '0;
    end else if (clk_en) begin
      if (stk.push) begin
        ptr <= ptr + 1'b1;
      end else if (stk.pop) begin
        ptr <= ptr_m1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && stk.push) begin
      mem[ptr] <= stk.push_data;
    end
  end

  // registered top of stack: the entry a pop will return
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stk.top_data <= pcs_pkg::PC_RESET;
    end else if (clk_en) begin
      if (stk.push) begin
        stk.top_data <= stk.push_data;
      end else if (stk.pop) begin
        stk.top_data <= mem[ptr_m2];
      end
    end
  end

  chk_ptr_wraps: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && stk.push && ptr == DEPTH-1) |=> ptr == 0)
    else $error("stack pointer did not wrap");
endmodule : pcs_stack

// >>> verification/pcs_core_model.sv
`timescale 1ns/1ps
module pcs_core_model (
  input  wire logic        clk_sys,
  output logic             clk_en,
  output logic             fetch,
  output logic             jump,
  output logic             call,
  output logic      [10:0] target,
  output logic             irq_vector,
  output logic             ret,
  output logic             low_wr,
  output logic      [7:0]  low_wdata,
  output logic             latch_wr,
  output logic      [7:0]  latch_wdata
);
  // ************
  // event issue
  // ************
  initial begin
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} = 8'h80;
    target = 11'h000;
    low_wdata = 8'h00;
    latch_wdata = 8'h00;
  end
  // one cycle of controls per op, events may combine, stacking only implied by call, irq and ret
  task automatic op(input logic [7:0] k, input logic [10:0] t, input logic [7:0] d);
    @(posedge clk_sys);
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} <= {~k[7], k[6:0]};
    target <= t;
    low_wdata <= d;
    latch_wdata <= d;
    @(posedge clk_sys);
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} <= 8'h80;
    target <= ~t;
    low_wdata <= ~d;
    latch_wdata <= ~d;
    #1;
  endtask : op
  // two events on consecutive edges, then idle
  task automatic op2(input logic [7:0] k1, input logic [10:0] t1, input logic [7:0] k2, input logic [10:0] t2);
    @(posedge clk_sys);
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} <= {~k1[7], k1[6:0]};
    target <= t1;
    @(posedge clk_sys);
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} <= {~k2[7], k2[6:0]};
    target <= t2;
    @(posedge clk_sys);
    {clk_en, latch_wr, low_wr, ret, irq_vector, call, jump, fetch} <= 8'h80;
    target <= ~t2;
    #1;
  endtask : op2
endmodule : pcs_core_model

// >>> verification/program_counter_stack_paging_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module program_counter_stack_paging_test;
  logic        clk_sys, reset = 1'b1, clk_en, fetch, jump, call, irq_vector, ret, low_wr, latch_wr;
  logic [10:0] target;
  logic [7:0]  low_wdata, latch_wdata, low, latch;
  logic [12:0] pc;
  int          fail_count = 0;
  int          samples_checked = 0;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  pcs_core_model core (.clk_sys(clk_sys), .clk_en(clk_en), .fetch(fetch), .jump(jump), .call(call),
    .target(target), .irq_vector(irq_vector), .ret(ret), .low_wr(low_wr), .low_wdata(low_wdata),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata));
  pcs_seq dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .fetch(fetch), .jump(jump), .call(call),
    .target(target), .irq_vector(irq_vector), .ret(ret), .low_wr(low_wr), .low_wdata(low_wdata),
    .latch_wr(latch_wr), .latch_wdata(latch_wdata), .pc(pc), .pc_low_byte_reg(low),
    .pc_high_holding_latch(latch));
  // ************
  // scenarios
  // ************
  task automatic test_reset;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(pc, 13'h0000)
    `CHK(latch, 8'h00)
    @(posedge clk_sys);
    reset <= 1'b0;
    core.op(8'h01, 11'h000, 8'h00);
    `CHK(pc, 13'h0001)
  endtask : test_reset
  task automatic test_low_write;
    core.op(8'h40, 11'h000, 8'h15);
    core.op(8'h20, 11'h000, 8'h80);
    `CHK(pc, 13'h1580)
    `CHK(low, 8'h80)
    core.op(8'h40, 11'h000, 8'h1F);
    core.op(8'h20, 11'h000, 8'hFF);
    core.op(8'h01, 11'h000, 8'h00);
    `CHK(pc, 13'h0000)
    core.op(8'h81, 11'h000, 8'h00);
    `CHK(pc, 13'h0000)
  endtask : test_low_write
  task automatic test_paging;
    core.op(8'h40, 11'h000, 8'h18);
    core.op(8'h02, 11'h123, 8'h00);
    `CHK(pc, 13'h1923)
    core.op(8'h40, 11'h000, 8'h08);
    core.op(8'h02, 11'h7FF, 8'h00);
    `CHK(pc, 13'h0FFF)
  endtask : test_paging
  task automatic test_stack;
    core.op(8'h40, 11'h000, 8'h0F);
    core.op(8'h02, 11'h010, 8'h00);
    for (int i = 0; i < 9; i++) core.op(8'h04, 11'(11'h100 + i), 8'h00);
    `CHK(pc, 13'h0908)
    for (int i = 0; i < 9; i++) begin
      core.op(8'h10, 11'h000, 8'h00);
      `CHK(pc, (i == 8) ? 13'h0908 : 13'(13'h0908 - i))
    end
    `CHK(latch, 8'h0F)
  endtask : test_stack
  task automatic test_irq;
    core.op(8'h02, 11'h234, 8'h00);
    core.op(8'h08, 11'h000, 8'h00);
    `CHK(pc, 13'h0004)
    core.op(8'h10, 11'h000, 8'h00);
    `CHK(pc, 13'h0A34)
    `CHK(latch, 8'h0F)
  endtask : test_irq
  task automatic test_back_to_back;
    core.op2(8'h04, 11'h055, 8'h10, 11'h000);
    `CHK(pc, 13'h0A35)
    core.op(8'h01, 11'h000, 8'h00);
    core.op2(8'h08, 11'h000, 8'h10, 11'h000);
    `CHK(pc, 13'h0A36)
    core.op(8'h14, 11'h0AA, 8'h00);
    `CHK(pc, 13'h08AA)
    core.op(8'h12, 11'h0BB, 8'h00);
    `CHK(pc, 13'h08BB)
    core.op(8'h10, 11'h000, 8'h00);
    `CHK(pc, 13'h0A37)
  endtask : test_back_to_back
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    test_reset();
    test_low_write();
    test_paging();
    test_stack();
    test_irq();
    test_back_to_back();
    test_reset();
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : program_counter_stack_paging_test
